/* File: core/swid_params.svh */
// Named constants for the single-wire serial-id bus master.
// Assumes a 100 MHz system clock; times are in microseconds.
`ifndef SWID_PARAMS_SVH
`define SWID_PARAMS_SVH

// ********************************************************************
// Clock and bus timing
// ********************************************************************
`define SWID_CLK_MHZ      100   // System clock rate in MHz
`define SWID_T_RSTL_US    480   // Reset low pulse, least
`define SWID_T_RSTH_US    480   // Released time after reset, least
`define SWID_T_PDS_US     70    // Presence sample point after release
`define SWID_T_SLOT_US    70    // Time slot length
`define SWID_T_REC_US     5     // Recovery between slots
`define SWID_T_LOW1_US    6     // Write-one / early low time
`define SWID_T_LOW0_US    65    // Write-zero low time
`define SWID_T_RLOW_US    2     // Read slot start pulse
`define SWID_T_RSAMP_US   13    // Read sample point
`define SWID_T_RDV_US     15    // Read data valid window
`define SWID_T_LOWMAX_US  960   // Longest low the line may see

// ********************************************************************
// Commands, sizes and check value
// ********************************************************************
`define SWID_CMD_READ_A   8'h33  // Identity read, current code
`define SWID_CMD_READ_B   8'h0F  // Identity read, legacy code
`define SWID_CMD_MATCH    8'h55  // Addressed access, device falls quiet
`define SWID_CMD_SKIP     8'hCC  // Broadcast access, device falls quiet
`define SWID_CRC_POLY     8'h8C  // x^8+x^5+x^4+1, bit-reversed form
`define SWID_CRC_INIT     8'h00  // Check register start value
`define SWID_CMD_LAST     3'h7   // Index of last command bit
`define SWID_ID_LAST      6'h3F  // Index of last identity bit

`endif

/* File: core/swid_pkg.sv */
// Types shared by the single-wire serial-id bus master.
// Assumes swid_params.svh is compiled alongside.
package swid_pkg;

  // ******************************************************************
  // Bus sequencer states
  // ******************************************************************
  typedef enum logic [2:0] {
    SWID_IDLE,
    SWID_RST_LOW,
    SWID_RST_HIGH,
    SWID_WR_SLOT,
    SWID_RD_SLOT,
    SWID_DONE
  } swid_state_t;

  // ******************************************************************
  // Identity layout, lowest byte first on the wire
  // ******************************************************************
  typedef struct packed {
    logic [7:0]  check;     // Check byte, received last
    logic [11:0] customer;  // Top of serial: assigned customer id
    logic [35:0] serial_lo; // Start value plus per-part increment
    logic [7:0]  family;    // Family byte, received first
  } swid_ident_t;

  // Result of one bus transaction
  typedef struct packed {
    logic        presence;  // A device answered the reset
    logic        crc_ok;    // Identity read and check matched
    swid_ident_t ident;     // Identity as received
  } swid_result_t;

endpackage : swid_pkg

/* File: core/swid_crc8.sv */
// Bit-serial check-value generator for the identity stream.
// Assumes bits arrive lowest first, one per enable, same clock.
`timescale 1ns/1ns
`include "swid_params.svh"

module swid_crc8 (
  input  wire logic       mclk_i,   // System clock
  input  wire logic       resetn_i, // Asynchronous reset, active low
  input  wire logic       clr_i,    // Restart the check register
  input  wire logic       en_i,     // One received bit is valid
  input  wire logic       bit_i,    // Received bit
  output logic [7:0]      crc_o     // Running remainder
);

  logic [7:0] crc_ff;               // Remainder register
  logic [7:0] nxt_crc;              // Next remainder
  logic       fb;                   // Feedback bit

  // ******************************************************************
  // Reflected shift: after the check byte itself a clean stream
  // leaves a zero remainder, so no separate compare is needed
  // ******************************************************************
  assign fb      = crc_ff[0] ^ bit_i;
  assign nxt_crc = {1'b0, crc_ff[7:1]} ^ ({8{fb}} & `SWID_CRC_POLY);

  // Remainder register
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      crc_ff <= `SWID_CRC_INIT;
    else if (clr_i)
      crc_ff <= `SWID_CRC_INIT;
    else if (en_i)
      crc_ff <= nxt_crc;
  end

  assign crc_o = crc_ff;

endmodule : swid_crc8

/* File: core/swid_master.sv */
// Bus master for a single-wire serial-id device on an open-drain line.
// Assumes an external pull-up on the line and a single device for reads.
`timescale 1ns/1ns
`include "swid_params.svh"

// Function
// - Last identity byte is x^8+x^5+x^4+1 check
// - Master checks remainder over received stream
// - Line released 480 us after reset
// - Reset low never beyond 960 us
// - Master samples read before 15 us
// - Write-one/read low 1 to 15 us
// - All bits travel lowest first
module swid_master #(
  parameter int RSTL_CYC  = `SWID_T_RSTL_US  * `SWID_CLK_MHZ,
  parameter int RSTH_CYC  = `SWID_T_RSTH_US  * `SWID_CLK_MHZ,
  parameter int PDS_CYC   = `SWID_T_PDS_US   * `SWID_CLK_MHZ,
  parameter int SLOT_CYC  = `SWID_T_SLOT_US  * `SWID_CLK_MHZ,
  parameter int REC_CYC   = `SWID_T_REC_US   * `SWID_CLK_MHZ,
  parameter int LOW1_CYC  = `SWID_T_LOW1_US  * `SWID_CLK_MHZ,
  parameter int LOW0_CYC  = `SWID_T_LOW0_US  * `SWID_CLK_MHZ,
  parameter int RLOW_CYC  = `SWID_T_RLOW_US  * `SWID_CLK_MHZ,
  parameter int RSAMP_CYC = `SWID_T_RSAMP_US * `SWID_CLK_MHZ
) (
  input  wire logic                  mclk_i,    // System clock
  input  wire logic                  resetn_i,  // Async reset, active low
  input  wire logic                  start_i,   // Begin a transaction
  input  wire logic [7:0]            cmd_i,     // Command byte to send
  input  wire logic                  dq_i,      // Line level from pin
  output logic                       dq_o,      // Line drive value
  output logic                       dq_oe_o,   // Pull line low when high
  output logic                       busy_o,    // Transaction running
  output logic                       done_o,    // One-cycle end pulse
  output swid_pkg::swid_result_t     result_o   // Last transaction result
);

  // ******************************************************************
  // Widths and derived limits
  // ******************************************************************
  localparam int CW      = 17;  // Covers the longest count at 100 MHz
  localparam int RDV_CYC = `SWID_T_RDV_US * `SWID_CLK_MHZ;
  localparam int LMX_CYC = `SWID_T_LOWMAX_US * `SWID_CLK_MHZ;

  // Refuse settings that break slot ordering or overflow the counter
  if (!(LOW1_CYC >= 1 && LOW1_CYC < RSAMP_CYC && RLOW_CYC < RSAMP_CYC &&
        RSAMP_CYC < RDV_CYC && LOW0_CYC < SLOT_CYC && REC_CYC >= 1 &&
        PDS_CYC < RSTH_CYC && RSTL_CYC < LMX_CYC &&
        RSTH_CYC < (1 << CW) && SLOT_CYC + REC_CYC < (1 << CW)))
  begin : g_bad_timing
    $error("swid_master: timing parameters out of order or too large");
  end

  localparam logic [CW-1:0] RSTL_L  = CW'(RSTL_CYC - 1);
  localparam logic [CW-1:0] RSTH_L  = CW'(RSTH_CYC - 1);
  localparam logic [CW-1:0] PDS_C   = CW'(PDS_CYC);
  localparam logic [CW-1:0] SLOT_L  = CW'(SLOT_CYC + REC_CYC - 1);
  localparam logic [CW-1:0] SLOT_C  = CW'(SLOT_CYC);
  localparam logic [CW-1:0] LOW1_C  = CW'(LOW1_CYC);
  localparam logic [CW-1:0] LOW0_C  = CW'(LOW0_CYC);
  localparam logic [CW-1:0] RLOW_C  = CW'(RLOW_CYC);
  localparam logic [CW-1:0] RSAMP_C = CW'(RSAMP_CYC);
  localparam logic [CW-1:0] RDV_C   = CW'(RDV_CYC);
  localparam logic [CW-1:0] LMX_C   = CW'(LMX_CYC);

  // ******************************************************************
  // Registers and named wires
  // ******************************************************************
  swid_pkg::swid_state_t  state_ff;     // Sequencer state
  swid_pkg::swid_state_t  nxt_state;    // Next state
  logic [CW-1:0]          cnt_ff;       // Cycles into current phase
  logic [CW-1:0]          nxt_cnt;      // Next count
  logic [5:0]             bit_ff;       // Bit index in current phase
  logic [5:0]             nxt_bit;      // Next bit index
  logic [7:0]             cmd_ff;       // Latched command
  logic [63:0]            shift_ff;     // Identity shift register
  logic                   pres_ff;      // Presence seen
  logic                   oe_ff;        // Registered line drive
  logic                   done_ff;      // End pulse register
  swid_pkg::swid_result_t res_ff;       // Result register
  logic [1:0]             sync_ff;      // Pin synchroniser
  logic [7:0]             crc_rem;      // Running check remainder
  logic                   dq_s;         // Synchronised line level
  logic                   cur_bit;      // Command bit in this slot
  logic                   slot_end;     // Last cycle of a slot
  logic                   last_wr;      // Final command slot
  logic                   last_rd;      // Final identity slot
  logic                   is_read;      // Command asks for identity
  logic                   samp;         // Read sample strobe
  logic                   pds;          // Presence sample strobe
  logic                   nxt_oe;       // Next line drive
  logic                   in_slot;      // In a write or read slot

  // ******************************************************************
  // Decode
  // ******************************************************************
  assign dq_s     = sync_ff[1];
  assign cur_bit  = cmd_ff[bit_ff[2:0]];
  assign in_slot  = (state_ff == swid_pkg::SWID_WR_SLOT) ||
                    (state_ff == swid_pkg::SWID_RD_SLOT);
  assign slot_end = in_slot && (cnt_ff == SLOT_L);
  assign last_wr  = bit_ff[2:0] == `SWID_CMD_LAST;
  assign last_rd  = bit_ff == `SWID_ID_LAST;
  assign is_read  = (cmd_ff == `SWID_CMD_READ_A) ||
                    (cmd_ff == `SWID_CMD_READ_B);
  // Late sample keeps pull-up recovery time, still inside valid window
  assign samp     = (state_ff == swid_pkg::SWID_RD_SLOT) &&
                    (cnt_ff == RSAMP_C);
  // Device low always covers this point if it keeps its windows
  assign pds      = (state_ff == swid_pkg::SWID_RST_HIGH) &&
                    (cnt_ff == PDS_C);

  // Line drive per phase; short write-one low lets the device see a
  // high at its own sample point, long write-zero low covers it
  always_comb
  begin
    case (state_ff)
      swid_pkg::SWID_RST_LOW: nxt_oe = 1'b1;
      swid_pkg::SWID_WR_SLOT: nxt_oe = cur_bit ? (cnt_ff < LOW1_C)
                                               : (cnt_ff < LOW0_C);
      swid_pkg::SWID_RD_SLOT: nxt_oe = cnt_ff < RLOW_C;
      default:                nxt_oe = 1'b0;
    endcase
  end

  // ******************************************************************
  // Sequencer
  // ******************************************************************
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      swid_pkg::SWID_IDLE:
        if (start_i)
          nxt_state = swid_pkg::SWID_RST_LOW;
      swid_pkg::SWID_RST_LOW:
        if (cnt_ff == RSTL_L)
          nxt_state = swid_pkg::SWID_RST_HIGH;
      swid_pkg::SWID_RST_HIGH:
        // Full release time before any slot, present or not
        if (cnt_ff == RSTH_L)
          nxt_state = pres_ff ? swid_pkg::SWID_WR_SLOT
                              : swid_pkg::SWID_DONE;
      swid_pkg::SWID_WR_SLOT:
        // Match, skip and unknown codes end after the command byte
        if (slot_end && last_wr)
          nxt_state = is_read ? swid_pkg::SWID_RD_SLOT
                              : swid_pkg::SWID_DONE;
      swid_pkg::SWID_RD_SLOT:
        if (slot_end && last_rd)
          nxt_state = swid_pkg::SWID_DONE;
      swid_pkg::SWID_DONE:
        nxt_state = swid_pkg::SWID_IDLE;
      default:
        nxt_state = swid_pkg::SWID_IDLE;
    endcase
  end

  // Counter restarts on every phase change and every slot
  assign nxt_cnt = ((nxt_state != state_ff) || slot_end) ? '0
                                                        : cnt_ff + 1'b1;
  assign nxt_bit = (nxt_state != state_ff) ? '0
                 : slot_end                ? bit_ff + 1'b1
                                           : bit_ff;

  // Synchroniser: only the second stage is read by logic
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      sync_ff <= 2'h3;
    else
      sync_ff <= {sync_ff[0], dq_i};
  end

  // State, counters and line drive
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= swid_pkg::SWID_IDLE;
      cnt_ff   <= '0;
      bit_ff   <= '0;
      oe_ff    <= 1'b0;
      done_ff  <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      bit_ff   <= nxt_bit;
      oe_ff    <= nxt_oe;
      done_ff  <= state_ff == swid_pkg::SWID_DONE;
    end
  end

  // Command latch, presence flag and identity shifter
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cmd_ff   <= '0;
      pres_ff  <= 1'b0;
      shift_ff <= '0;
    end
    else if (state_ff == swid_pkg::SWID_IDLE && start_i)
    begin
      cmd_ff   <= cmd_i;
      pres_ff  <= 1'b0;
      shift_ff <= '0;
    end
    else
    begin
      if (pds)
        pres_ff <= ~dq_s;
      if (samp)
        shift_ff <= {dq_s, shift_ff[63:1]};
    end
  end

  // Result is captured once, as the transaction ends
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      res_ff <= '0;
    else if (state_ff == swid_pkg::SWID_DONE)
    begin
      res_ff.presence <= pres_ff;
      res_ff.crc_ok   <= pres_ff && is_read && (crc_rem == 8'h00);
      res_ff.ident    <= shift_ff;
    end
  end

  // Check generator runs over all 64 received bits
  swid_crc8 u_crc (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .clr_i    (state_ff == swid_pkg::SWID_IDLE),
    .en_i     (samp),
    .bit_i    (dq_s),
    .crc_o    (crc_rem)
  );

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign dq_o     = 1'b0;   // Open drain: only ever pulls low
  assign dq_oe_o  = oe_ff;  // Registered so the pin never glitches
  assign busy_o   = state_ff != swid_pkg::SWID_IDLE;
  assign done_o   = done_ff;
  assign result_o = res_ff;

  // ******************************************************************
  // Checks
  // ******************************************************************
  logic [CW-1:0] low_run_ff;  // Consecutive cycles with line driven
  always_ff @(posedge mclk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      low_run_ff <= '0;
    else
      low_run_ff <= oe_ff ? low_run_ff + 1'b1 : '0;
  end

  sequence s_last_cmd_slot;
    state_ff == swid_pkg::SWID_WR_SLOT && slot_end && last_wr;
  endsequence

  a_low_max: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    low_run_ff < LMX_C)
    else $error("line held low too long");
  a_reset_gap: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (state_ff == swid_pkg::SWID_RST_HIGH && cnt_ff != RSTH_L)
    |=> !dq_oe_o && state_ff == swid_pkg::SWID_RST_HIGH)
    else $error("release after reset cut short");
  a_reset_len: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(state_ff == swid_pkg::SWID_RST_HIGH)
    |-> $past(cnt_ff) == RSTL_L && dq_oe_o)
    else $error("reset low length wrong");
  a_wr1_low: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (state_ff == swid_pkg::SWID_WR_SLOT && cur_bit && cnt_ff == LOW1_C)
    |=> !dq_oe_o)
    else $error("write-one low too long");
  a_wr0_low: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (state_ff == swid_pkg::SWID_WR_SLOT && !cur_bit && cnt_ff == LOW0_C - 1'b1)
    |=> dq_oe_o ##1 !dq_oe_o)
    else $error("write-zero low length wrong");
  a_rec_gap: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (in_slot && cnt_ff >= SLOT_C) |=> !dq_oe_o)
    else $error("no recovery between slots");
  a_rd_sample: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    samp |-> cnt_ff < RDV_C && $past(oe_ff, 2) == 1'b0)
    else $error("read sample outside window");
  a_quiet_cmd: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (s_last_cmd_slot and !is_read) |=> state_ff == swid_pkg::SWID_DONE
    ##1 done_o && !busy_o)
    else $error("bus activity after non-read command");
  a_read_len: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (state_ff == swid_pkg::SWID_RD_SLOT && slot_end)
    |=> (state_ff == swid_pkg::SWID_DONE) == ($past(bit_ff) == `SWID_ID_LAST))
    else $error("identity length wrong");
  a_crc_flag: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    $rose(done_o) |-> result_o.crc_ok == ($past(crc_rem, 2) == 8'h00 &&
                      $past(pres_ff, 2) && $past(is_read, 2)))
    else $error("check flag does not match remainder");

endmodule : swid_master

/* File: bench/swid_dev_model.sv */
// Behavioural model of the serial-id device on the single-wire line.
// Assumes one bench cycle stands for one microsecond of line time.
`timescale 1ns/1ns

module swid_dev_model (
  input  wire logic        mclk_i,   // Bench clock, one cycle per us
  input  wire logic        line_i,   // Resolved line level
  input  wire logic        absent_i, // Device unplugged when high
  input  wire logic [63:0] ident_i,  // Identity, check on top
  input  wire logic [7:0]  pdh_i,    // Wait before presence
  input  wire logic [7:0]  pdl_i,    // Presence low length
  output logic             pull_o    // High while device pulls low
);
  // ******************************************************************
  // Slot engine, started by every falling edge of the line
  // ******************************************************************
  int         n;     // Cycles the line stayed low
  int         bitn;  // Bit index in command or identity
  int         mode;  // 0 quiet, 1 command, 2 identity read
  logic       smp;   // Sampled write bit
  logic [7:0] cmd;   // Command as received

  initial
  begin
    pull_o = 1'b0;
    mode = 0;
    bitn = 0;
    cmd = 8'h00;
    forever
    begin
      @(posedge mclk_i);
      if (line_i === 1'b0)
      begin
        n = 0;
        // Zero bit: pull at once, hold to 15 us after the fall
        if (mode == 2 && !absent_i && !ident_i[bitn])
          pull_o <= 1'b1;
        while (line_i === 1'b0)
        begin
          @(posedge mclk_i);
          n++;
          if (n == 14)
            pull_o <= 1'b0;
        end
        // Sample point sits between write-one and write-zero lows
        if (n < 30)
        begin
          repeat (30 - n) @(posedge mclk_i);
          smp = line_i;
        end
        else
          smp = 1'b0;
        if (n >= 240)
        begin
          // Reset seen: answer with presence
          repeat (pdh_i) @(posedge mclk_i);
          pull_o <= !absent_i;
          repeat (pdl_i) @(posedge mclk_i);
          pull_o <= 1'b0;
          mode = 1;
          bitn = 0;
        end
        else if (mode == 1)
        begin
          cmd[bitn] = smp;
          bitn++;
          if (bitn == 8)
          begin
            bitn = 0;
            // Read codes start the identity, others fall silent
            mode = (cmd == 8'h33 || cmd == 8'h0F) ? 2 : 0;
          end
        end
        else if (mode == 2)
        begin
          bitn++;
          mode = (bitn == 64) ? 0 : 2;
        end
      end
    end
  end
endmodule : swid_dev_model

/* File: bench/single_wire_serial_id_slave_tb.sv */
// Self-checking bench for the single-wire serial-id bus master.
// Assumes swid_dev_model; design timings scaled to one cycle per us.
`timescale 1ns/1ns
`include "swid_params.svh"

`define CHK(nm, ex, gt) \
  begin \
    cmp_count++; \
    if ((gt) !== (ex)) \
    begin \
      fails++; \
      $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); \
    end \
  end

module single_wire_serial_id_slave_tb;
  // ******************************************************************
  // Expected identity
  // ******************************************************************
  // Reflected form of x^8+x^5+x^4+1, lowest bit first
  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    return c;
  endfunction : crc8

  localparam logic [7:0]  FAM  = 8'h5A;           // Arbitrary family
  localparam logic [11:0] CUST = 12'hA5C;         // Customer id field
  localparam logic [35:0] SER  = 36'h1_2345_6789; // Start value part
  localparam logic [55:0] BODY = {CUST, SER, FAM};
  localparam logic [63:0] ID   = {crc8(BODY), BODY};

  logic                   mclk_i;    // Bench clock
  logic                   resetn_i;  // Reset, active low
  logic                   start_i;   // Start request
  logic [7:0]             cmd_i;     // Command byte
  logic                   absent;    // Device unplugged
  logic                   pull;      // Device pulls line low
  logic [7:0]             pdh;       // Presence wait
  logic [7:0]             pdl;       // Presence length
  logic [63:0]            ident;     // Identity given to device
  wire logic              dq_o;      // Master drive value
  wire logic              dq_oe_o;   // Master pulls line low
  wire logic              busy_o;    // Master busy
  wire logic              done_o;    // Master done pulse
  swid_pkg::swid_result_t result_o;  // Master result
  // Open-drain line with pull-up: any puller wins
  wire logic              line = (dq_oe_o ? dq_o : 1'b1) & !pull;
  int                     fails = 0;
  int                     cmp_count = 0;
  int                     pulls;     // Device pull pulses this run

  // One bench cycle per microsecond keeps the run short
  localparam int RSTL_B  = `SWID_T_RSTL_US;  // Reset low, cycles
  localparam int RSTH_B  = `SWID_T_RSTH_US;  // Release after reset
  localparam int PDS_B   = `SWID_T_PDS_US;   // Presence sample point
  localparam int SLOT_B  = `SWID_T_SLOT_US;  // Slot length
  localparam int REC_B   = `SWID_T_REC_US;   // Recovery gap
  localparam int LOW1_B  = `SWID_T_LOW1_US;  // Write-one low
  localparam int LOW0_B  = `SWID_T_LOW0_US;  // Write-zero low
  localparam int RLOW_B  = `SWID_T_RLOW_US;  // Read start low
  localparam int RSAMP_B = `SWID_T_RSAMP_US; // Read sample point

  swid_master #(
    .RSTL_CYC  (RSTL_B),
    .RSTH_CYC  (RSTH_B),
    .PDS_CYC   (PDS_B),
    .SLOT_CYC  (SLOT_B),
    .REC_CYC   (REC_B),
    .LOW1_CYC  (LOW1_B),
    .LOW0_CYC  (LOW0_B),
    .RLOW_CYC  (RLOW_B),
    .RSAMP_CYC (RSAMP_B)
  ) dut_u (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .start_i  (start_i),
    .cmd_i    (cmd_i),
    .dq_i     (line),
    .dq_o     (dq_o),
    .dq_oe_o  (dq_oe_o),
    .busy_o   (busy_o),
    .done_o   (done_o),
    .result_o (result_o)
  );

  swid_dev_model dev_u (
    .mclk_i   (mclk_i),
    .line_i   (line),
    .absent_i (absent),
    .ident_i  (ident),
    .pdh_i    (pdh),
    .pdl_i    (pdl),
    .pull_o   (pull)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ******************************************************************
  // Line monitor: master low lengths and gaps
  // ******************************************************************
  int   lo_n = 0;     // Cycles of current master low
  int   hi_n = 1000;  // Cycles since master released
  int   plen = 1000;  // Previous master low length
  logic oe_q = 1'b0;  // Master pull, one cycle late
  logic pl_q = 1'b0;  // Device pull, one cycle late
  wire logic len_ok = (lo_n >= 1 && lo_n <= 15) ||
                      (lo_n >= 60 && lo_n <= 120) ||
                      (lo_n >= 480 && lo_n < 960);

  always @(posedge mclk_i)
  begin
    oe_q <= dq_oe_o;
    pl_q <= pull;
    lo_n <= dq_oe_o ? lo_n + 1 : 0;
    hi_n <= dq_oe_o ? 0 : hi_n + 1;
    if (pull && !pl_q)
      pulls++;
    if (!dq_oe_o && oe_q)
    begin
      `CHK("low_len", 1'b1, len_ok)
      plen <= lo_n;
    end
    if (dq_oe_o && !oe_q)
    begin
      `CHK("gap", 1'b1, hi_n >= ((plen >= 480) ? 480 : 1))
      `CHK("slot", 1'b1, plen + hi_n >= 60)
    end
  end

  // ******************************************************************
  // Transaction and scenarios
  // ******************************************************************
  task automatic run(input logic [7:0] c);
    int k;
    @(negedge mclk_i);
    pulls = 0;
    cmd_i = c;
    start_i = 1'b1;
    @(negedge mclk_i);
    start_i = 1'b0;
    k = 0;
    // Bounded wait: a read takes under 7000 cycles
    while (done_o !== 1'b1 && k < 20000)
    begin
      @(negedge mclk_i);
      k++;
    end
    `CHK("done", 1'b1, done_o)
  endtask : run

  task automatic t_absent;
    absent = 1'b1;
    run(8'h33);
    `CHK("presence", 1'b0, result_o.presence)
    `CHK("ident", 64'h0000_0000_0000_0000, result_o.ident)
    `CHK("pulls", 0, pulls)
    absent = 1'b0;
    $display("test absent done");
  endtask : t_absent

  task automatic t_read(input logic [7:0] c, h, l);
    pdh = h;
    pdl = l;
    run(c);
    `CHK("presence", 1'b1, result_o.presence)
    `CHK("crc_ok", 1'b1, result_o.crc_ok)
    `CHK("ident", ID, result_o.ident)
    `CHK("customer", CUST, result_o.ident.customer)
    `CHK("pulls", 65 - $countones(ID), pulls)
    $display("test read %0h done", c);
  endtask : t_read

  task automatic t_quiet(input logic [7:0] c);
    run(c);
    `CHK("presence", 1'b1, result_o.presence)
    `CHK("crc_ok", 1'b0, result_o.crc_ok)
    `CHK("pulls", 1, pulls)
    $display("test quiet %0h done", c);
  endtask : t_quiet

  // Flipped check bit must be caught by the master
  task automatic t_bad;
    ident = ID ^ {8'h01, 56'h0};
    run(8'h33);
    `CHK("crc_bad", 1'b0, result_o.crc_ok)
    `CHK("ident_bad", ident, result_o.ident)
    ident = ID;
    $display("test bad check done");
  endtask : t_bad

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  initial
  begin
    resetn_i = 1'b0;
    start_i = 1'b0;
    cmd_i = 8'h00;
    absent = 1'b0;
    ident = ID;
    pdh = 8'h0F;
    pdl = 8'h3C;
    repeat (8) @(negedge mclk_i);
    resetn_i = 1'b1;
    t_absent;
    t_read(8'h33, 8'h0F, 8'hF0); // Prompt presence, long low
    t_read(8'h0F, 8'h3C, 8'h3C); // Slow presence, short low
    t_quiet(8'h55);
    t_quiet(8'hCC);
    t_bad;
    end_sim;
  end

  // Watchdog: all scenarios need about 23200 cycles
  initial
  begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    $display("timeout reached");
    end_sim;
  end
endmodule : single_wire_serial_id_slave_tb
